// [core/brf_defs.svh]
// Constants of the banked register file
`ifndef BRF_DEFS_SVH
`define BRF_DEFS_SVH
`define BRF_FLAG_N 31
`define BRF_FLAG_Z 30
`define BRF_FLAG_C 29
`define BRF_FLAG_V 28
`define BRF_BIT_I 7
`define BRF_BIT_F 6
`define BRF_BIT_T 5
`define BRF_MODE_HI 4
`define BRF_PSR_MASK 32'hF00000FF
`define BRF_PSR_RESET 32'h000000D3
`define BRF_OFS_PSR 32'h00000000
`define BRF_OFS_SAVED_STATUS_WORD 32'h00000004
`define BRF_OFS_MODE 32'h00000008
`endif

// [core/brf_pkg.sv]
// Types of the banked register file
package brf_pkg;
    typedef enum logic [4:0] {
        BRF_USR = 5'h10,
        BRF_FIQ = 5'h11,
        BRF_IRQ = 5'h12,
        BRF_SVC = 5'h13,
        BRF_ABT = 5'h17,
        BRF_UND = 5'h1B,
        BRF_SYS = 5'h1F
    } brf_mode_e;
    typedef enum logic [1:0] {
        BRF_SZ_BYTE = 2'h0,
        BRF_SZ_HALF = 2'h1,
        BRF_SZ_WORD = 2'h2
    } brf_size_e;
endpackage

// [core/brf_regfile.sv]
// Mode-banked register file with AHB-Lite status access
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "brf_defs.svh"
module brf_regfile
    import brf_pkg::*;
#(
    parameter int DW = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] rd_a_idx,
    input wire logic [3:0] rd_b_idx,
    input wire logic narrow_hi_ok,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic pc_wr,
    input wire logic [31:0] pc_next,
    input wire logic branch_with_link,
    input wire logic [31:0] link_value,
    input wire logic flags_wr,
    input wire logic [3:0] flags_in,
    input wire logic exc_take,
    input wire logic [4:0] exc_mode,
    input wire logic [31:0] exc_return,
    input wire logic exc_set_f,
    input wire logic exc_leave,
    input wire logic psr_wr,
    input wire logic [31:0] psr_data,
    input wire logic [3:0] cond_code,
    input wire logic is_branch,
    input wire logic [1:0] mem_size,
    input wire logic [1:0] mem_addr_lo,
    input wire logic irq_req,
    input wire logic fiq_req,
    output logic [31:0] rd_a_data,
    output logic [31:0] rd_b_data,
    output logic [31:0] pc_out,
    output logic [31:0] status_out,
    output logic state_output_signal,
    output logic privileged,
    output logic mode_illegal,
    output logic cond_pass,
    output logic misaligned,
    output logic irq_taken,
    output logic fiq_taken
);
    if (DW != 32) begin : g_dw_check
        $error("brf_regfile supports only 32-bit data");
    end

    // 16 shared plus 7 fiq, 2 each for irq/svc/abt/und: 31 general with pc
    logic [31:0] gpr_q [0:15];
    logic [31:0] fiq_q [8:14];
    logic [31:0] bank_q [0:3][13:14];
    logic [31:0] current_status_word_q;
    logic [31:0] saved_status_word_q [0:4];
    logic ahb_ph_q;
    logic [31:0] ahb_addr_q;
    logic ahb_wr_q;

    function automatic int bank_of(input logic [4:0] m);
        case (m)
            BRF_IRQ: bank_of = 0;
            BRF_SVC: bank_of = 1;
            BRF_ABT: bank_of = 2;
            BRF_UND: bank_of = 3;
            default: bank_of = -1;
        endcase
    endfunction

    function automatic int saved_status_word_of(input logic [4:0] m);
        case (m)
            BRF_FIQ: saved_status_word_of = 4;
            default: saved_status_word_of = bank_of(m);
        endcase
    endfunction

    function automatic logic mode_ok(input logic [4:0] m);
        case (m)
            BRF_USR, BRF_FIQ, BRF_IRQ, BRF_SVC, BRF_ABT, BRF_UND, BRF_SYS: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    endfunction

    logic [4:0] mode;
    logic tstate;
    assign mode = current_status_word_q[`BRF_MODE_HI:0];
    assign tstate = current_status_word_q[`BRF_BIT_T];

    // Banked view of a register index
    function automatic logic [31:0] view(input logic [3:0] i);
        int b;
        b = bank_of(mode);
        if (i == 4'hF) begin
            view = tstate ? {gpr_q[15][31:1], 1'b0} : {gpr_q[15][31:2], 2'b00};
        end else if (mode == BRF_FIQ && i >= 4'h8) begin
            view = fiq_q[i];
        end else if (b >= 0 && i >= 4'hD) begin
            view = bank_q[b][i];
        end else begin
            view = gpr_q[i];
        end
    endfunction

    // Narrow state blocks high registers except sp/lr/pc or special ops
    function automatic logic reach(input logic [3:0] i);
        reach = !tstate || i < 4'h8 || i >= 4'hD || narrow_hi_ok;
    endfunction

    logic n_f, z_f, c_f, v_f, cpass;
    assign n_f = current_status_word_q[`BRF_FLAG_N];
    assign z_f = current_status_word_q[`BRF_FLAG_Z];
    assign c_f = current_status_word_q[`BRF_FLAG_C];
    assign v_f = current_status_word_q[`BRF_FLAG_V];

    // Condition evaluation; narrow state conditions branches only
    always_comb begin
        logic r;
        r = 1'b1;
        case (cond_code[3:1])
            3'h0: r = z_f;
            3'h1: r = c_f;
            3'h2: r = n_f;
            3'h3: r = v_f;
            3'h4: r = c_f && !z_f;
            3'h5: r = n_f == v_f;
            3'h6: r = !z_f && (n_f == v_f);
            default: r = 1'b1;
        endcase
        if (cond_code[0] && cond_code[3:1] != 3'h7) r = !r;
        cpass = (tstate && !is_branch) ? 1'b1 : r;
    end

    logic mis;
    always_comb begin
        case (mem_size)
            BRF_SZ_HALF: mis = mem_addr_lo[0];
            BRF_SZ_WORD: mis = |mem_addr_lo;
            default: mis = 1'b0;
        endcase
    end

    logic psr_sel_wr;
    assign psr_sel_wr = ahb_ph_q && ahb_wr_q && ahb_addr_q == `BRF_OFS_PSR;
    logic saved_status_word_sel_wr;
    assign saved_status_word_sel_wr = ahb_ph_q && ahb_wr_q && ahb_addr_q == `BRF_OFS_SAVED_STATUS_WORD;

    // General register writes and link capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 16; i++) gpr_q[i] <= 32'h00000000;
            for (int i = 8; i < 15; i++) fiq_q[i] <= 32'h00000000;
            for (int b = 0; b < 4; b++) begin
                bank_q[b][13] <= 32'h00000000;
                bank_q[b][14] <= 32'h00000000;
            end
        end else if (clk_en) begin
            if (wr_en && wr_idx != 4'hF && reach(wr_idx)) begin
                if (mode == BRF_FIQ && wr_idx >= 4'h8) fiq_q[wr_idx] <= wr_data;
                else if (bank_of(mode) >= 0 && wr_idx >= 4'hD)
                    bank_q[bank_of(mode)][wr_idx] <= wr_data;
                else gpr_q[wr_idx] <= wr_data;
            end
            if (branch_with_link) begin
                if (mode == BRF_FIQ) fiq_q[14] <= link_value;
                else if (bank_of(mode) >= 0) bank_q[bank_of(mode)][14] <= link_value;
                else gpr_q[14] <= link_value;
            end
            if (exc_take && mode_ok(exc_mode)) begin
                if (exc_mode == BRF_FIQ) fiq_q[14] <= exc_return;
                else if (bank_of(exc_mode) >= 0) bank_q[bank_of(exc_mode)][14] <= exc_return;
            end
            if (pc_wr) gpr_q[15] <= pc_next;
        end
    end

    // Status words: exception entry/exit, software and flag updates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            current_status_word_q <= `BRF_PSR_RESET;
            for (int i = 0; i < 5; i++) saved_status_word_q[i] <= 32'h00000000;
        end else if (clk_en) begin
            if (exc_take && mode_ok(exc_mode)) begin
                if (saved_status_word_of(exc_mode) >= 0) saved_status_word_q[saved_status_word_of(exc_mode)] <= current_status_word_q;
                current_status_word_q[`BRF_MODE_HI:0] <= exc_mode;
                current_status_word_q[`BRF_BIT_T] <= 1'b0;
                current_status_word_q[`BRF_BIT_I] <= 1'b1;
                if (exc_set_f) current_status_word_q[`BRF_BIT_F] <= 1'b1;
            end else if (exc_leave && saved_status_word_of(mode) >= 0) begin
                current_status_word_q <= saved_status_word_q[saved_status_word_of(mode)];
            end else begin
                if ((psr_wr || psr_sel_wr) && mode != BRF_USR) begin
                    current_status_word_q <= (psr_sel_wr ? hwdata : psr_data) & `BRF_PSR_MASK;
                end else if ((psr_wr || psr_sel_wr) && mode == BRF_USR) begin
                    current_status_word_q[31:28] <= psr_sel_wr ? hwdata[31:28] : psr_data[31:28];
                end
                if (flags_wr) current_status_word_q[31:28] <= flags_in;
                if (saved_status_word_sel_wr && saved_status_word_of(mode) >= 0)
                    saved_status_word_q[saved_status_word_of(mode)] <= hwdata & `BRF_PSR_MASK;
            end
        end
    end

    // AHB-Lite slave: one wait-free data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_ph_q <= 1'b0;
            ahb_addr_q <= 32'h00000000;
            ahb_wr_q <= 1'b0;
        end else if (clk_en) begin
            ahb_ph_q <= hsel && hready && htrans[1] && hsize == 3'h2;
            ahb_addr_q <= haddr;
            ahb_wr_q <= hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (clk_en) begin
            if (hsel && hready && htrans[1] && hsize == 3'h2 && !hwrite) begin
                case (haddr)
                    `BRF_OFS_PSR: hrdata <= current_status_word_q & `BRF_PSR_MASK;
                    `BRF_OFS_SAVED_STATUS_WORD: hrdata <= saved_status_word_of(mode) >= 0 ?
                        saved_status_word_q[saved_status_word_of(mode)] & `BRF_PSR_MASK : 32'h00000000;
                    `BRF_OFS_MODE: hrdata <= {29'h0, privileged, mode_illegal, tstate};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Registered core-facing outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_a_data <= 32'h00000000;
            rd_b_data <= 32'h00000000;
            pc_out <= 32'h00000000;
            status_out <= `BRF_PSR_RESET;
            state_output_signal <= 1'b0;
            privileged <= 1'b1;
            mode_illegal <= 1'b0;
            cond_pass <= 1'b0;
            misaligned <= 1'b0;
            irq_taken <= 1'b0;
            fiq_taken <= 1'b0;
        end else if (clk_en) begin
            rd_a_data <= reach(rd_a_idx) ? view(rd_a_idx) : 32'h00000000;
            rd_b_data <= reach(rd_b_idx) ? view(rd_b_idx) : 32'h00000000;
            pc_out <= view(4'hF);
            status_out <= current_status_word_q & `BRF_PSR_MASK;
            state_output_signal <= tstate;
            privileged <= mode != BRF_USR;
            mode_illegal <= !mode_ok(mode);
            cond_pass <= cpass;
            misaligned <= mis;
            irq_taken <= irq_req && !current_status_word_q[`BRF_BIT_I];
            fiq_taken <= fiq_req && !current_status_word_q[`BRF_BIT_F];
        end
    end

    property p_state_output_signal;
        @(posedge hclk) disable iff (!hresetn)
        clk_en |=> state_output_signal == $past(current_status_word_q[`BRF_BIT_T]);
    endproperty
    a_state_output_signal: assert property (p_state_output_signal) else $error("state output mismatch");

    property p_irq_mask;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && current_status_word_q[`BRF_BIT_I] |=> !irq_taken;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq taken");

    property p_fiq_mask;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && current_status_word_q[`BRF_BIT_F] |=> !fiq_taken;
    endproperty
    a_fiq_mask: assert property (p_fiq_mask) else $error("masked fiq taken");

    property p_resv;
        @(posedge hclk) disable iff (!hresetn)
        status_out[27:8] == 20'h00000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits nonzero");

    property p_pc_align;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && !tstate |=> pc_out[1:0] == 2'b00;
    endproperty
    a_pc_align: assert property (p_pc_align) else $error("pc not word aligned");

    sequence s_enter;
        clk_en && exc_take && exc_mode == BRF_IRQ;
    endsequence
    property p_exc_enter;
        @(posedge hclk) disable iff (!hresetn)
        s_enter |=> current_status_word_q[`BRF_MODE_HI:0] == BRF_IRQ && current_status_word_q[`BRF_BIT_I]
            && bank_q[0][14] == $past(exc_return);
    endproperty
    a_exc_enter: assert property (p_exc_enter) else $error("irq entry wrong");

    property p_priv;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && mode == BRF_USR |=> !privileged;
    endproperty
    a_priv: assert property (p_priv) else $error("user marked privileged");

    property p_flags;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && flags_wr && !exc_take && !exc_leave |=> current_status_word_q[31:28] == $past(flags_in);
    endproperty
    a_flags: assert property (p_flags) else $error("flags not updated");

    property p_misalign;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && mem_size == BRF_SZ_WORD && mem_addr_lo == 2'h2 |=> misaligned;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misalign missed");

    property p_pc_half;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && tstate |=> !pc_out[0];
    endproperty
    a_pc_half: assert property (p_pc_half) else $error("pc not halfword aligned");

    // Fast entry: own mode, fast mask set, private link loaded
    sequence s_fiq_enter;
        clk_en && exc_take && exc_mode == BRF_FIQ && exc_set_f;
    endsequence
    property p_fiq_enter;
        @(posedge hclk) disable iff (!hresetn)
        s_fiq_enter |=> current_status_word_q[`BRF_MODE_HI:0] == BRF_FIQ && current_status_word_q[`BRF_BIT_F]
            && fiq_q[14] == $past(exc_return);
    endproperty
    a_fiq_enter: assert property (p_fiq_enter) else $error("fiq entry wrong");

    property p_narrow_hi;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && tstate && !narrow_hi_ok && rd_a_idx >= 4'h8 && rd_a_idx <= 4'hC
            |=> rd_a_data == 32'h00000000;
    endproperty
    a_narrow_hi: assert property (p_narrow_hi) else $error("high register leaked");
endmodule

// [tb/brf_pipe_model.sv]
// Behavioural model of the core pipeline's exception sequencer
`timescale 1ns/1ps
module brf_pipe_model
    import brf_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_line,
    input wire logic fiq_line,
    input wire logic irq_taken,
    input wire logic fiq_taken,
    input wire logic [31:0] cur_pc,
    output logic irq_req,
    output logic fiq_req,
    output logic exc_take,
    output logic [4:0] exc_mode,
    output logic [31:0] exc_return,
    output logic exc_set_f
);
    logic busy_q;
    // Request withdrawn once accepted, until the source lets go
    assign irq_req = irq_line & !busy_q;
    assign fiq_req = fiq_line & !busy_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 1'b0;
        end else if (irq_taken | fiq_taken) begin
            busy_q <= 1'b1;
        end else if (!irq_line && !fiq_line) begin
            busy_q <= 1'b0;
        end
    end
    // Entry with return address of next word, fast entry masks fast requests
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exc_take <= 1'b0;
            exc_mode <= BRF_SVC;
            exc_return <= 32'h00000000;
            exc_set_f <= 1'b0;
        end else begin
            exc_take <= (irq_taken | fiq_taken) & !busy_q;
            exc_mode <= fiq_taken ? BRF_FIQ : BRF_IRQ;
            exc_return <= cur_pc + 32'h00000004;
            exc_set_f <= fiq_taken;
        end
    end
endmodule

// [tb/brf_regfile_tb.sv]
// Self-checking bench of the banked register file
`timescale 1ns/1ps
`include "brf_defs.svh"
module brf_regfile_tb
    import brf_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, wr_data, pc_next, link_value, exc_return;
    logic [31:0] psr_data, rd_a_data, rd_b_data, pc_out, status_out;
    logic [1:0] htrans, mem_size, mem_addr_lo;
    logic [2:0] hsize;
    logic [3:0] rd_a_idx, rd_b_idx, wr_idx, flags_in, cond_code;
    logic clk_en, narrow_hi_ok, is_branch;
    logic [4:0] exc_mode;
    logic wr_en, pc_wr, branch_with_link, flags_wr, exc_take, exc_set_f, exc_leave, psr_wr;
    logic irq_req, fiq_req, irq_line, fiq_line, state_output_signal, privileged;
    logic mode_illegal, cond_pass, misaligned, irq_taken, fiq_taken;
    int err_total, samples_checked;
    int cycles = 0;
    logic [4:0] mds [6] = '{BRF_FIQ, BRF_IRQ, BRF_SVC, BRF_ABT, BRF_UND, BRF_SYS};
    logic [4:0] mis [5] = '{5'h06, 5'h0B, 5'h08, 5'h15, 5'h10};

    brf_regfile brf_regfile_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx), .narrow_hi_ok(narrow_hi_ok), .wr_en(wr_en),
        .wr_idx(wr_idx), .wr_data(wr_data), .pc_wr(pc_wr), .pc_next(pc_next),
        .branch_with_link(branch_with_link), .link_value(link_value), .flags_wr(flags_wr),
        .flags_in(flags_in), .exc_take(exc_take), .exc_mode(exc_mode),
        .exc_return(exc_return), .exc_set_f(exc_set_f), .exc_leave(exc_leave),
        .psr_wr(psr_wr), .psr_data(psr_data), .cond_code(cond_code), .is_branch(is_branch),
        .mem_size(mem_size), .mem_addr_lo(mem_addr_lo), .irq_req(irq_req),
        .fiq_req(fiq_req), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .pc_out(pc_out),
        .status_out(status_out), .state_output_signal(state_output_signal),
        .privileged(privileged), .mode_illegal(mode_illegal), .cond_pass(cond_pass),
        .misaligned(misaligned), .irq_taken(irq_taken), .fiq_taken(fiq_taken));
    brf_pipe_model brf_pipe_model_i (.hclk(hclk), .hresetn(hresetn), .irq_line(irq_line),
        .fiq_line(fiq_line), .irq_taken(irq_taken), .fiq_taken(fiq_taken), .cur_pc(pc_out),
        .irq_req(irq_req), .fiq_req(fiq_req), .exc_take(exc_take), .exc_mode(exc_mode),
        .exc_return(exc_return), .exc_set_f(exc_set_f));

    initial hclk = 1'b0;
    always #12.5 hclk = ~hclk;

    task automatic report_and_stop();
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        if (!w) chk(hrdata, d);
        if (w) cyc(2);
    endtask
    task automatic rreg(input logic [3:0] i, input logic [31:0] e);
        rd_a_idx <= i;
        rd_b_idx <= i;
        cyc(2);
        chk(rd_a_data, e);
        chk(rd_b_data, e);
    endtask
    task automatic pulse_wait();
        @(posedge hclk);
        {wr_en, pc_wr, branch_with_link, flags_wr, exc_leave, psr_wr} <= 6'h00;
        cyc(3);
    endtask
    // Distinct contents per physical bank, shared banks get one value
    function automatic logic [31:0] bankval(input logic [4:0] m, input logic [3:0] i);
        logic [4:0] b;
        b = 5'h10;
        if (m == BRF_FIQ && i > 4'h7) b = m;
        if ((m == BRF_IRQ || m == BRF_SVC || m == BRF_ABT || m == BRF_UND) && i > 4'hC) b = m;
        if (i < 4'h8) b = 5'h00;
        return {19'h0, b, 4'h0, i};
    endfunction

    initial begin
        {hsel, hwrite, wr_en, pc_wr, branch_with_link, flags_wr, exc_leave, psr_wr} = 8'h00;
        {irq_line, fiq_line, narrow_hi_ok, is_branch} = 4'h0;
        clk_en = 1'b1;
        cond_code = 4'hE;
        {haddr, hwdata, wr_data, pc_next, link_value, psr_data} = '0;
        {htrans, mem_size, mem_addr_lo, rd_a_idx, rd_b_idx, wr_idx, flags_in} = '0;
        hsize = 3'h2;
        err_total = 0;
        samples_checked = 0;
        hresetn = 1'b0;
        cyc(3);
        hresetn <= 1'b1;
        cyc(2);
        chk(status_out, 32'h000000D3);
        chk(privileged, 32'h1);
        chk(hresp, 32'h0);
        ahb(1'b0, `BRF_OFS_PSR, 32'h000000D3);
        ahb(1'b1, `BRF_OFS_PSR, 32'h0FFFFF1F);
        ahb(1'b0, `BRF_OFS_PSR, 32'h0000001F);
        ahb(1'b0, 32'h00000010, 32'h00000000);
        ahb(1'b1, `BRF_OFS_PSR, 32'h000000D4);
        chk(mode_illegal, 32'h1);
        for (int p = 0; p < 2; p++) begin
            foreach (mds[k]) begin
                ahb(1'b1, `BRF_OFS_PSR, {24'h0, 3'b110, mds[k]});
                chk(mode_illegal, 32'h0);
                chk(privileged, 32'h1);
                for (int j = 7; j < 15; j++) begin
                    if (p == 0) begin
                        wr_en <= 1'b1;
                        wr_idx <= 4'(j);
                        wr_data <= bankval(mds[k], 4'(j));
                        @(posedge hclk);
                    end else begin
                        rreg(4'(j), bankval(mds[k], 4'(j)));
                    end
                end
                wr_en <= 1'b0;
            end
        end
        ahb(1'b1, `BRF_OFS_PSR, 32'h000000D2);
        branch_with_link <= 1'b1;
        link_value <= 32'h0000ABC4;
        flags_wr <= 1'b1;
        flags_in <= 4'hA;
        pulse_wait();
        rreg(4'hE, 32'h0000ABC4);
        chk(status_out, 32'hA00000D2);
        chk(cond_pass, 32'h1);
        cond_code <= 4'h0;
        cyc(2);
        chk(cond_pass, 32'h0);
        ahb(1'b1, `BRF_OFS_SAVED_STATUS_WORD, 32'hFFFFFFD2);
        ahb(1'b0, `BRF_OFS_SAVED_STATUS_WORD, 32'hF00000D2);
        foreach (mis[k]) begin
            mem_size <= mis[k][4:3];
            mem_addr_lo <= mis[k][2:1];
            cyc(3);
            chk(misaligned, {31'h0, mis[k][0]});
        end
        ahb(1'b1, `BRF_OFS_PSR, 32'h000000F3);
        chk(state_output_signal, 32'h1);
        ahb(1'b0, `BRF_OFS_MODE, 32'h00000005);
        rreg(4'hD, bankval(BRF_SVC, 4'hD));
        rreg(4'h8, 32'h00000000);
        narrow_hi_ok <= 1'b1;
        rreg(4'h8, bankval(BRF_SVC, 4'h8));
        narrow_hi_ok <= 1'b0;
        chk(cond_pass, 32'h1);
        is_branch <= 1'b1;
        cyc(2);
        chk(cond_pass, 32'h0);
        is_branch <= 1'b0;
        cond_code <= 4'hE;
        pc_wr <= 1'b1;
        pc_next <= 32'h00001003;
        pulse_wait();
        chk(pc_out, 32'h00001002);
        ahb(1'b1, `BRF_OFS_PSR, 32'h000000D3);
        chk(state_output_signal, 32'h0);
        pc_wr <= 1'b1;
        pc_next <= 32'h00002003;
        pulse_wait();
        chk(pc_out, 32'h00002000);
        irq_line <= 1'b1;
        fiq_line <= 1'b1;
        cyc(4);
        chk({fiq_taken, irq_taken}, 32'h0);
        {irq_line, fiq_line} <= 2'h0;
        ahb(1'b1, `BRF_OFS_PSR, 32'h00000010);
        chk(privileged, 32'h0);
        psr_wr <= 1'b1;
        psr_data <= 32'h500000D3;
        pulse_wait();
        chk(status_out, 32'h50000010);
        clk_en <= 1'b0;
        psr_wr <= 1'b1;
        psr_data <= 32'hF0000000;
        pulse_wait();
        chk(status_out, 32'h50000010);
        clk_en <= 1'b1;
        ahb(1'b0, `BRF_OFS_SAVED_STATUS_WORD, 32'h00000000);
        irq_line <= 1'b1;
        cyc(8);
        irq_line <= 1'b0;
        cyc(3);
        chk({27'h0, status_out[4:0]}, 32'h12);
        ahb(1'b0, `BRF_OFS_SAVED_STATUS_WORD, 32'h50000010);
        rreg(4'hE, 32'h00002004);
        exc_leave <= 1'b1;
        pulse_wait();
        chk(status_out, 32'h50000010);
        fiq_line <= 1'b1;
        cyc(8);
        fiq_line <= 1'b0;
        cyc(3);
        chk({26'h0, status_out[6], status_out[4:0]}, 32'h31);
        rreg(4'h8, bankval(BRF_FIQ, 4'h8));
        rreg(4'hE, 32'h00002004);
        report_and_stop();
    end
endmodule
